// [rtl/wdt_params.svh]
// wdt_params.svh: offsets, field positions, reset values and timing counts for the watchdog
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH

// register byte addresses on the wishbone slave
`define WDT_ADDR_SERVICE   16'hFFFF
`define WDT_ADDR_CTRL      16'h0000
`define WDT_ADDR_STATUS    16'h0004
`define WDT_ADDR_VECLO     16'h0008

// control register fields
`define WDT_CTRL_DISABLE   0
`define WDT_CTRL_LONG      1
`define WDT_CTRL_STOPEN    2
`define WDT_CTRL_MONITOR   3
`define WDT_CTRL_BREAK     4
`define WDT_CTRL_RESET     8'h00

// status register fields
`define WDT_STAT_CAUSE     0
`define WDT_STAT_RSTOUT    1
`define WDT_STAT_STOPPED   2
`define WDT_STAT_PORDONE   3

// widths and timing counts
`define WDT_PRE_BITS       12
`define WDT_CNT_BITS       6
`define WDT_PRE_KEEP       12'h007
`define WDT_PRE_TOP        12'hFFF
`define WDT_PRE_FIRE       12'hFEF
`define WDT_CNT_TOP_SHORT  6'h01
`define WDT_CNT_TOP_LONG   6'h3F
`define WDT_POR_CYCLES     4096
`define WDT_RST_CYCLES     32
`define WDT_VEC_LO_RESET   8'h00

`endif

// [rtl/wdt_pkg.sv]
// wdt_pkg.sv: types shared by the watchdog design
package wdt_pkg;

  // state of the timeout sequencer
  typedef enum logic [2:0]
  {
    WDT_POR   = 3'b001,
    WDT_RUN   = 3'b010,
    WDT_FIRE  = 3'b100
  } wdt_state_t;

  // control inputs from the device configuration and system
  typedef struct packed
  {
    logic disable_cfg;
    logic long_sel;
    logic stop_en;
    logic monitor_mode;
    logic break_state;
  } wdt_cfg_t;

endpackage : wdt_pkg

// [rtl/wdt_core.sv]
// wdt_core.sv: watchdog timeout counter with a wishbone register slave
//
// Function
// R1: any service write clears counter, prescaler stages 4-12
// R2: service at top address; read returns vector byte
// R3: stop instruction clears the prescaler
// R4: power-on logic clears prescaler after 4096 cycles
// R5: internal reset clears prescaler and counter
// R6: reset vector fetch clears the prescaler
// R7: disable input blocks any watchdog reset
// R8: rate select picks short or long timeout
// R9: never raises an interrupt, only resets
// R10: monitor mode plus test voltage disables watchdog
// R11: keeps counting during wait mode
// R12: software services from interrupt during wait
// R13: stop gates clock and clears prescaler
// R14: software services before and after stop
// R15: stop only honoured when stop-enable set
// R16: break plus reset-pin test voltage disables
// R17: counts the crystal clock
// R18: six-bit counter behind twelve-bit prescaler
// R19: expiry after 2^13-2^4 or 2^18-2^4 cycles
// R20: reset pin low 32 cycles, cause flag set
// R21: disabled watchdog holds counter and prescaler cleared
`include "wdt_params.svh"

module wdt_core #(
  parameter int POR_CYCLES = `WDT_POR_CYCLES,
  parameter int RST_CYCLES = `WDT_RST_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // system events
  input  wire logic        xtal_tick_i,
  input  wire logic        stop_exec_i,
  input  wire logic        stop_exit_i,
  input  wire logic        internal_reset_i,
  input  wire logic        vector_fetch_i,
  input  wire logic        wait_mode_i,
  input  wire logic        hv_irq_pin_i,
  input  wire logic        hv_rst_pin_i,
  // reset output
  output logic             rst_pin_n_o,
  output logic             watchdog_reset_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [`WDT_PRE_BITS-1:0] pre;
  logic [`WDT_PRE_BITS-1:0] next_pre;
  logic [`WDT_CNT_BITS-1:0] cnt;
  logic [`WDT_CNT_BITS-1:0] next_cnt;
  logic [12:0]              por_cnt;
  logic [12:0]              next_por_cnt;
  logic [5:0]               rst_cnt;
  logic [5:0]               next_rst_cnt;
  logic [7:0]               ctrl;
  logic [7:0]               next_ctrl;
  logic                     cause;
  logic                     next_cause;
  logic                     stopped;
  logic                     next_stopped;
  logic [7:0]               vec_lo;
  logic [7:0]               next_vec_lo;
  logic [31:0]              next_dat;
  logic                     next_ack;
  logic                     next_rst_n;
  logic                     next_wdr;
  wdt_pkg::wdt_state_t      state;
  wdt_pkg::wdt_state_t      next_state;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic hit(input logic [15:0] a, input logic [15:0] b);
    hit = (a == b);
  endfunction : hit

  logic req;
  logic wr;
  logic svc_wr;
  logic off;
  logic run_ok;
  logic expire;
  logic [`WDT_CNT_BITS-1:0] top;
  logic pre_fire;
  logic cnt_top;
  logic clr_now;

  // request qualifiers and disable conditions
  assign req      = cyc_i && stb_i && !ack_o;
  // a write lands at the edge where the master sees ack, request still held
  assign wr       = cyc_i && stb_i && we_i && ack_o;
  assign svc_wr   = wr && hit(adr_i, `WDT_ADDR_SERVICE);        // [R1] [R2]
  // any one of the three conditions parks the watchdog
  assign off      = ctrl[`WDT_CTRL_DISABLE]                     // [R7]
                  | (ctrl[`WDT_CTRL_MONITOR] && (hv_irq_pin_i || hv_rst_pin_i)) // [R10]
                  | (ctrl[`WDT_CTRL_BREAK] && hv_rst_pin_i);   // [R16]
  // wait mode does not stop counting; stop freezes the clock
  assign run_ok   = xtal_tick_i && !stopped && (state == wdt_pkg::WDT_RUN); // [R11] [R13] [R17]
  // the long select only moves the counter's compare point
  assign top      = ctrl[`WDT_CTRL_LONG] ? `WDT_CNT_TOP_LONG : `WDT_CNT_TOP_SHORT; // [R8]
  // expiry lands 2^4 ticks before the prescaler would wrap
  assign pre_fire = (pre == `WDT_PRE_FIRE);                     // [R19]
  assign cnt_top  = (cnt == top);                               // [R8]
  // a service write or internal reset in the same cycle beats the expiry
  assign clr_now  = svc_wr || internal_reset_i;                 // [R1] [R5]
  assign expire   = run_ok && !off && pre_fire && cnt_top && !clr_now; // [R19]

  ////////////////////////////////////////////////////////////////////////////
  // prescaler, counter and sequencer next state
  always_comb
  begin
    next_pre     = pre;
    next_cnt     = cnt;
    next_por_cnt = por_cnt;
    next_rst_cnt = rst_cnt;
    next_state   = state;
    next_stopped = stopped;
    next_cause   = cause;
    next_rst_n   = rst_pin_n_o;
    next_wdr     = watchdog_reset_o;
    unique case (state)
      // power-on delay: wait out the start-up ticks
      wdt_pkg::WDT_POR:
      begin
        if (xtal_tick_i)
        begin
          next_por_cnt = por_cnt + 13'h0001;
        end
        if (por_cnt == 13'(POR_CYCLES))
        begin
          next_pre   = '0;                                  // [R4]
          next_state = wdt_pkg::WDT_RUN;
        end
      end
      // normal counting on crystal ticks
      wdt_pkg::WDT_RUN:
      begin
        if (run_ok)
        begin
          next_pre = pre + 12'h001;                          // [R18]
          if (pre == `WDT_PRE_TOP)
          begin
            next_cnt = cnt + 6'h01;
          end
        end
        if (expire)
        begin
          next_state   = wdt_pkg::WDT_FIRE;
          next_rst_cnt = '0;
          next_rst_n   = 1'b0;                               // [R20]
          next_wdr     = 1'b1;
          next_cause   = 1'b1;                               // [R20]
          next_pre     = '0;
          next_cnt     = '0;
        end
      end
      // reset pin held low while ticks are counted
      wdt_pkg::WDT_FIRE:
      begin
        if (xtal_tick_i)
        begin
          next_rst_cnt = rst_cnt + 6'h01;
        end
        // release on the tick that closes the last low cycle
        if (xtal_tick_i && (rst_cnt == 6'(RST_CYCLES - 1)))
        begin
          next_rst_n = 1'b1;                                 // [R20]
          next_wdr   = 1'b0;
          next_state = wdt_pkg::WDT_RUN;
        end
      end
      default:
      begin
        next_state = wdt_pkg::WDT_RUN;
      end
    endcase
    // clearing events override counting
    if (stop_exec_i && ctrl[`WDT_CTRL_STOPEN])               // [R15]
    begin
      next_pre     = '0;                                     // [R3] [R13]
      next_stopped = 1'b1;
    end
    // leaving stop lets the crystal ticks through again
    if (stop_exit_i)
    begin
      next_stopped = 1'b0;
    end
    // a vector fetch restarts only the prescaler
    if (vector_fetch_i)
    begin
      next_pre = '0;                                         // [R6]
    end
    // service keeps the three lowest prescaler stages
    if (svc_wr)
    begin
      next_pre = pre & `WDT_PRE_KEEP;                        // [R1]
      next_cnt = '0;
    end
    // a parked watchdog stays at zero; a running pulse finishes first
    if (off && state != wdt_pkg::WDT_FIRE)
    begin
      next_pre = '0;                                         // [R21]
      next_cnt = '0;
    end
    // internal reset wins over every other event
    if (internal_reset_i)
    begin
      next_pre = '0;                                         // [R5]
      next_cnt = '0;
    end
    // software clears the cause flag by writing a one
    if (wr && hit(adr_i, `WDT_ADDR_STATUS) && sel_i[0] && dat_i[`WDT_STAT_CAUSE] && !expire)
    begin
      next_cause = 1'b0;                                     // set wins over clear
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register slave next state: config, vector byte, read data
  always_comb
  begin
    next_ctrl   = ctrl;
    next_vec_lo = vec_lo;
    next_ack    = req;
    next_dat    = '0;
    // configuration byte, upper three bits read as zero
    if (wr && sel_i[0] && hit(adr_i, `WDT_ADDR_CTRL))
    begin
      next_ctrl = {3'h0, dat_i[4:0]};
    end
    // stand-in for the reset vector low byte
    if (wr && sel_i[0] && hit(adr_i, `WDT_ADDR_VECLO))
    begin
      next_vec_lo = dat_i[7:0];
    end
    // read data is latched at the taking edge and stands with ack
    if (req && !we_i)
    begin
      if (hit(adr_i, `WDT_ADDR_SERVICE))
      begin
        next_dat = {24'h000000, vec_lo};                     // [R2]
      end
      else if (hit(adr_i, `WDT_ADDR_CTRL))
      begin
        next_dat = {24'h000000, ctrl};
      end
      else if (hit(adr_i, `WDT_ADDR_STATUS))
      begin
        next_dat = {28'h0000000, (state != wdt_pkg::WDT_POR), stopped, !rst_pin_n_o, cause};
      end
      else if (hit(adr_i, `WDT_ADDR_VECLO))
      begin
        next_dat = {24'h000000, vec_lo};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; no interrupt output exists
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre              <= '0;
      cnt              <= '0;
      por_cnt          <= '0;
      rst_cnt          <= '0;
      state            <= wdt_pkg::WDT_POR;
      stopped          <= 1'b0;
      cause            <= 1'b0;
      ctrl             <= `WDT_CTRL_RESET;
      vec_lo           <= `WDT_VEC_LO_RESET;
      dat_o            <= '0;
      ack_o            <= 1'b0;
      rst_pin_n_o      <= 1'b1;
      watchdog_reset_o <= 1'b0;                              // [R9]
    end
    else
    begin
      pre              <= next_pre;
      cnt              <= next_cnt;
      por_cnt          <= next_por_cnt;
      rst_cnt          <= next_rst_cnt;
      state            <= next_state;
      stopped          <= next_stopped;
      cause            <= next_cause;
      ctrl             <= next_ctrl;
      vec_lo           <= next_vec_lo;
      dat_o            <= next_dat;
      ack_o            <= next_ack;
      rst_pin_n_o      <= next_rst_n;
      watchdog_reset_o <= next_wdr;
    end
  end

endmodule : wdt_core

// [bench/wdt_core_sva.sv]
// wdt_core_sva.sv: concurrent checks on the watchdog ports
module wdt_core_sva #(
  parameter int RST_CYCLES = 32
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // bus and events
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [15:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        xtal_tick_i,
  input wire logic        internal_reset_i,
  // reset outputs
  input wire logic        rst_pin_n_o,
  input wire logic        watchdog_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  int low_cnt;
  int next_low_cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // ticks spent with the reset pin low
  always_comb
  begin
    next_low_cnt = rst_pin_n_o ? 0 : low_cnt + int'(xtal_tick_i);
  end
  always_ff @(posedge clk_i)
  begin
    low_cnt <= rst_i ? 0 : next_low_cnt;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // bus request taken, and a service write among them
  sequence take_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence svc_s;
    take_s ##0 (we_i && adr_i == 16'hFFFF) ##1 (ack_o && rst_pin_n_o);
  endsequence
  chk_ack_answer: assert property (take_s |=> ack_o) else $error("no ack after request");
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  chk_pin_pair: assert property (watchdog_reset_o == !rst_pin_n_o)
    else $error("reset flag and pin disagree");
  chk_low_len: assert property ($rose(rst_pin_n_o) |-> low_cnt == RST_CYCLES)
    else $error("reset pulse length wrong");
  chk_reset_vals: assert property (disable iff (1'b0)
    rst_i |=> !ack_o && rst_pin_n_o && !watchdog_reset_o && dat_o == 32'h0)
    else $error("outputs not idle after reset");
  chk_int_clear: assert property (internal_reset_i && rst_pin_n_o |=> rst_pin_n_o [*8])
    else $error("expiry right after internal reset");
  chk_svc_clear: assert property (svc_s |=> rst_pin_n_o [*8])
    else $error("expiry right after service write");
  chk_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule : wdt_core_sva

bind wdt_core wdt_core_sva #(.RST_CYCLES(RST_CYCLES)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .xtal_tick_i(xtal_tick_i), .internal_reset_i(internal_reset_i),
  .rst_pin_n_o(rst_pin_n_o), .watchdog_reset_o(watchdog_reset_o));

// [bench/wdt_core_tb.sv]
// wdt_core_tb.sv: self-checking bench for the watchdog timeout counter
`include "wdt_params.svh"
module wdt_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic [15:0] adr_i;
  logic [31:0] dat_i, dat_o, rd;
  logic        tick, stp, ext, irst, vf, wt, hvq, hvr, pin_n, wdr;
  logic [7:0]  cfg [4] = '{8'h01, 8'h08, 8'h10, 8'h02};
  int          bad_count, num_checks, lows;
  ////////////////////////////////////////////////////////////////////////////////
  // device under test with a short power-on delay
  wdt_core #(.POR_CYCLES(8), .RST_CYCLES(32)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'h1), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .xtal_tick_i(tick), .stop_exec_i(stp), .stop_exit_i(ext),
    .internal_reset_i(irst), .vector_fetch_i(vf), .wait_mode_i(wt), .hv_irq_pin_i(hvq),
    .hv_rst_pin_i(hvr), .rst_pin_n_o(pin_n), .watchdog_reset_o(wdr));
  ////////////////////////////////////////////////////////////////////////////////
  // one classic wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    if (n >= 20)
    begin
      bad_count++;
      $display("[ERR] t=%0t no ack got=%h exp=%h", $time, ack_o, 1'b1);
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // wait n cycles, counting cycles with the reset pin low
  task automatic run(input int n);
    lows = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      if (pin_n !== 1'b1)
        lows++;
    end
  endtask : run
  // report and stop
  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////////
  // clock, 50 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // hang guard
  initial
  begin
    repeat (95000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
  // main sequence
  initial
  begin
    {cyc_i, stb_i, we_i, stp, ext, irst, vf, wt, hvq, hvr} = '0;
    adr_i = 16'h0000;
    dat_i = 32'h0;
    tick  = 1'b1;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    run(12);
    wb(1'b1, `WDT_ADDR_VECLO, 32'hA5);
    wb(1'b0, `WDT_ADDR_SERVICE, 32'h0);
    chk(rd, 32'hA5);
    wb(1'b0, 16'h0100, 32'h0);
    chk(rd, 32'h0);
    wt <= 1'b1;
    repeat (2)
    begin
      wb(1'b1, `WDT_ADDR_SERVICE, 32'h5A);
      run(5000);
      chk(lows, 0);
    end
    irst <= 1'b1;
    @(posedge clk_i);
    irst <= 1'b0;
    run(5000);
    chk(lows, 0);
    wb(1'b1, `WDT_ADDR_SERVICE, 32'h0);
    lows = 0;
    while (pin_n !== 1'b0 && lows < 9000)
    begin
      @(posedge clk_i);
      lows++;
    end
    chk(lows inside {[8169:8176]}, 1);
    run(40);
    chk(lows + 1, 32);
    wb(1'b0, `WDT_ADDR_STATUS, 32'h0);
    chk(rd[0], 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b1, `WDT_ADDR_CTRL, {24'h0, cfg[i]});
      hvq <= (i == 1);
      hvr <= (i == 2);
      wb(1'b1, `WDT_ADDR_SERVICE, 32'h0);
      run(8500);
      chk(lows, 0);
    end
    // stop with stop enabled freezes the count
    wb(1'b1, `WDT_ADDR_CTRL, 32'h04);
    wb(1'b1, `WDT_ADDR_SERVICE, 32'h0);
    stp <= 1'b1;
    @(posedge clk_i);
    stp <= 1'b0;
    run(8500);
    chk(lows, 0);
    ext <= 1'b1;
    @(posedge clk_i);
    ext <= 1'b0;
    wb(1'b1, `WDT_ADDR_SERVICE, 32'h0);
    // stop refused without enable; vector fetch restarts the prescaler
    wb(1'b1, `WDT_ADDR_CTRL, 32'h00);
    wb(1'b1, `WDT_ADDR_SERVICE, 32'h0);
    run(5000);
    vf  <= 1'b1;
    stp <= 1'b1;
    @(posedge clk_i);
    vf  <= 1'b0;
    stp <= 1'b0;
    run(3500);
    chk(lows, 0);
    run(1500);
    chk(lows, 32);
    summarize();
  end
endmodule : wdt_core_tb
